// *** ddc_pkg.sv ***
// package: command codes, field layout and reset values for the dual dac command decoder
package ddc_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 10;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 12;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 2;
    localparam int SEL_MSB = 1;
    localparam int SEL_LSB = 0;
    localparam int PD_BOTH_BIT = 4;
    localparam int PD_CHB_BIT = 2;
    localparam logic [3:0] CMD_LOAD_A = 4'h0;
    localparam logic [3:0] CMD_LOAD_B = 4'h1;
    localparam logic [3:0] CMD_HOLD_A = 4'h4;
    localparam logic [3:0] CMD_HOLD_B = 4'h5;
    localparam logic [3:0] CMD_XFER_A = 4'h8;
    localparam logic [3:0] CMD_XFER_B = 4'h9;
    localparam logic [3:0] CMD_LOAD_AB = 4'hC;
    localparam logic [3:0] CMD_HOLD_AB = 4'hD;
    localparam logic [3:0] CMD_XFER_AB = 4'hE;
    localparam logic [3:0] CMD_POWER = 4'hF;
    typedef enum logic [1:0] {
        DDC_PD_AWAKE = 2'b00,
        DDC_PD_FLOAT = 2'b01,
        DDC_PD_1K = 2'b10,
        DDC_PD_100K = 2'b11
    } ddc_pd_e;
    localparam ddc_pd_e PD_RESET = DDC_PD_100K;
    localparam logic [9:0] CODE_RESET = 10'h000;
    localparam logic [4:0] BITCNT_RESET = 5'h00;
endpackage

// *** ddc_decoder.sv ***
// dual dac serial command decoder: frame capture, register pair per channel, power-down
//
// Function
// - a frame is 16 bits msb first: 4 command bits, 10 code bits, then 2 power-down select bits.
// - codes 0000 and 0001 load the code straight into the dac register of channel a or b.
// - codes 0100 and 0101 load only the input register of channel a or b.
// - codes 1000 and 1001 copy the input register of channel a or b into its dac register.
// - code 1100 loads the code straight into both dac registers.
// - code 1101 loads the code into both input registers only.
// - code 1110 copies both input registers into both dac registers at once.
// - code 1111 is power control; data bit 2 picks both, else data bit 0 picks b over a.
// - select 00 wakes, 01 floats, 10 ends in 1k and 11 ends in 100k for the targeted outputs.
// - the code is straight binary, output equals reference times code over 1024.
// - a frame starts at chip select falling, bits sampled on falling sclk, acted on at bit 16.
// - chip select rising before the frame completes discards the partial word.
// - reset clears all registers and powers both channels down with 100k termination.
`timescale 1ns/1ns
module ddc_decoder
    import ddc_pkg::*;
#(
    parameter int WIDTH = CODE_BITS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // serial pins, asynchronous to core_clk
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    // channel a converter drive
    output logic [WIDTH-1:0] channel_a_output,
    output logic [1:0] channel_a_powerdown,
    output logic [WIDTH-1:0] channel_a_input_reg,
    // channel b converter drive
    output logic [WIDTH-1:0] channel_b_output,
    output logic [1:0] channel_b_powerdown,
    output logic [WIDTH-1:0] channel_b_input_reg,
    // status
    output logic frame_done
);
    // elaboration checks: the field layout must match the port widths
    if (WIDTH != CODE_BITS) begin : g_bad_width
        $error("ddc_decoder: WIDTH must equal the 10-bit code field");
    end
    if (CODE_MSB - CODE_LSB + 1 != WIDTH) begin : g_bad_code
        $error("ddc_decoder: code field position does not match WIDTH");
    end
    if (CMD_MSB != FRAME_BITS - 1 || SEL_LSB != 0) begin : g_bad_frame
        $error("ddc_decoder: frame layout does not fill the shift register");
    end
    if (FRAME_BITS >= 32) begin : g_bad_count
        $error("ddc_decoder: bit counter is only five bits wide");
    end

    // two-flop synchronisers; first stage read only by second
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic cs_n_prev_q;
    logic sclk_prev_q;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= {cs_n, sclk, din};
            sync2_q <= sync1_q;
        end
    end

    // edge history; reset high so a select idling high gives no false edge
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cs_n_prev_q <= 1'b1;
            sclk_prev_q <= 1'b1;
        end else begin
            cs_n_prev_q <= sync2_q[2];
            sclk_prev_q <= sync2_q[1];
        end
    end

    logic cs_low;
    logic cs_fall;
    logic sclk_fall;
    assign cs_low = ~sync2_q[2];
    assign cs_fall = cs_n_prev_q & ~sync2_q[2];
    assign sclk_fall = sclk_prev_q & ~sync2_q[1];

    // shift register and bit counter; count stops at 16 so later clocks are ignored
    logic [FRAME_BITS-1:0] shift_q;
    logic [4:0] bitcnt_q;
    logic word_ready;
    assign word_ready = cs_low && sclk_fall && (bitcnt_q == 5'(FRAME_BITS - 1));
    always_ff @(posedge core_clk) begin
        if (srst || !cs_low || cs_fall) begin
            bitcnt_q <= BITCNT_RESET;
            shift_q <= '0;
        end else if (sclk_fall && bitcnt_q != 5'(FRAME_BITS)) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], sync2_q[0]};
            bitcnt_q <= bitcnt_q + 5'h01;
        end
    end

    // full word including the bit arriving this cycle
    logic [FRAME_BITS-1:0] word;
    logic [3:0] command_field;
    logic [WIDTH-1:0] code_field;
    logic [1:0] powerdown_state_select;
    assign word = {shift_q[FRAME_BITS-2:0], sync2_q[0]};
    assign command_field = word[CMD_MSB:CMD_LSB];
    assign code_field = word[CODE_MSB:CODE_LSB];
    assign powerdown_state_select = word[SEL_MSB:SEL_LSB];

    localparam int CHANNELS = 2;

    // per-channel strobes, bit 0 is channel a and bit 1 is channel b
    logic [CHANNELS-1:0] hold_hit;
    logic [CHANNELS-1:0] load_hit;
    logic [CHANNELS-1:0] xfer_hit;
    logic [CHANNELS-1:0] pd_hit;
    // decode is gated by word_ready, so a cut frame strobes nothing
    always_comb begin
        hold_hit = '0;
        load_hit = '0;
        xfer_hit = '0;
        if (word_ready) begin
            unique case (command_field)
                CMD_LOAD_A: begin
                    load_hit = 2'b01;
                end
                CMD_LOAD_B: begin
                    load_hit = 2'b10;
                end
                CMD_HOLD_A: begin
                    hold_hit = 2'b01;
                end
                CMD_HOLD_B: begin
                    hold_hit = 2'b10;
                end
                CMD_XFER_A: begin
                    xfer_hit = 2'b01;
                end
                CMD_XFER_B: begin
                    xfer_hit = 2'b10;
                end
                CMD_LOAD_AB: begin
                    load_hit = 2'b11;
                end
                CMD_HOLD_AB: begin
                    hold_hit = 2'b11;
                end
                CMD_XFER_AB: begin
                    xfer_hit = 2'b11;
                end
                default: ;
            endcase
        end
    end

    // power targets; only state flops change, codes are kept
    // data bits 9 to 3 of a power command are never looked at
    logic pd_cmd;
    assign pd_cmd = word_ready && (command_field == CMD_POWER);
    assign pd_hit[0] = pd_cmd & (word[PD_BOTH_BIT] | ~word[PD_CHB_BIT]);
    assign pd_hit[1] = pd_cmd & (word[PD_BOTH_BIT] | word[PD_CHB_BIT]);

    // one register pair and power state per channel
    // flops live in the generate block so each has one driver
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        logic [WIDTH-1:0] input_q;
        logic [WIDTH-1:0] dac_q;
        logic [1:0] pd_q;

        // input register
        always_ff @(posedge core_clk) begin
            if (srst) begin
                input_q <= CODE_RESET;
            end else if (hold_hit[ch]) begin
                input_q <= code_field;
            end
        end

        // dac register; a transfer takes the value held before this frame
        always_ff @(posedge core_clk) begin
            if (srst) begin
                dac_q <= CODE_RESET;
            end else if (load_hit[ch]) begin
                dac_q <= code_field;
            end else if (xfer_hit[ch]) begin
                dac_q <= input_q;
            end
        end

        // power state
        always_ff @(posedge core_clk) begin
            if (srst) begin
                pd_q <= PD_RESET;
            end else if (pd_hit[ch]) begin
                pd_q <= powerdown_state_select;
            end
        end
    end

    // ports straight from the channel flops
    assign channel_a_input_reg = g_chan[0].input_q;
    assign channel_a_output = g_chan[0].dac_q;
    assign channel_a_powerdown = g_chan[0].pd_q;

    assign channel_b_input_reg = g_chan[1].input_q;
    assign channel_b_output = g_chan[1].dac_q;
    assign channel_b_powerdown = g_chan[1].pd_q;

    // one-cycle pulse when a full word was acted on
    always_ff @(posedge core_clk) begin
        if (srst) begin
            frame_done <= 1'b0;
        end else begin
            frame_done <= word_ready;
        end
    end
endmodule

// *** ddc_host.sv ***
// host model: shifts words msb first, link clock idle low
`timescale 1ns/1ns
module ddc_host (
    input wire logic core_clk,
    output logic cs_n = 1'b1,
    output logic sclk = 1'b0,
    output logic din = 1'b0
);
    // n below 16 abandons the word; released din flips so no stale bit
    task automatic send(input logic [15:0] w, input int n);
        @(negedge core_clk);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #62 sclk = 1'b1;
            din = w[15-i];
            #63 sclk = 1'b0;
        end
        #63 din = ~din;
        cs_n = 1'b1;
        #80;
        if (w[15:12] == 4'hF && w[1:0] == 2'h0)
            #8000;
    endtask
endmodule

// *** ddc_decoder_chk.sv ***
// checker: reset and update timing of the decoder outputs
`timescale 1ns/1ns
module ddc_decoder_chk #(parameter int WIDTH = 10) (
    input wire logic core_clk, srst, cs_n, frame_done,
    input wire logic [WIDTH-1:0] channel_a_output, channel_a_input_reg, channel_b_output, channel_b_input_reg,
    input wire logic [1:0] channel_a_powerdown, channel_b_powerdown
);
    wire [2*WIDTH+1:0] sa = {channel_a_output, channel_a_input_reg, channel_a_powerdown};
    wire [2*WIDTH+1:0] sb = {channel_b_output, channel_b_input_reg, channel_b_powerdown};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_done_gap; !frame_done [*8]; endsequence
    a_reset_a: assert property (disable iff (1'b0) srst |=> sa == {{(2*WIDTH){1'b0}}, 2'h3})
        else $error("a not reset");
    a_reset_b: assert property (disable iff (1'b0) srst |=> sb == {{(2*WIDTH){1'b0}}, 2'h3})
        else $error("b not reset");
    a_done_gap: assert property (frame_done |=> s_done_gap) else $error("done repeats");
    a_done_framed: assert property (frame_done |-> $past(cs_n, 2) == 1'b0) else $error("done unframed");
    a_a_quiet: assert property (!$stable(sa) |-> frame_done) else $error("a moved alone");
    a_b_quiet: assert property (!$stable(sb) |-> frame_done) else $error("b moved alone");
    a_a_pd_keeps: assert property (!$stable(channel_a_powerdown) |-> $stable(sa[2*WIDTH+1:2]))
        else $error("a codes lost");
    a_b_pd_keeps: assert property (!$stable(channel_b_powerdown) |-> $stable(sb[2*WIDTH+1:2]))
        else $error("b codes lost");
endmodule
bind ddc_decoder ddc_decoder_chk #(.WIDTH(WIDTH)) u_chk (.core_clk, .srst, .cs_n, .frame_done, .channel_a_output,
    .channel_a_input_reg, .channel_b_output, .channel_b_input_reg, .channel_a_powerdown, .channel_b_powerdown);

// *** test_dual_dac_serial_command_decoder.sv ***
// testbench: host frames into the decoder, state checked after each batch of one to three frames
`timescale 1ns/1ns
module test_dual_dac_serial_command_decoder;
    import ddc_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    wire cs_n, sclk, din, frame_done;
    wire [9:0] channel_a_output, channel_a_input_reg, channel_b_output, channel_b_input_reg;
    wire [1:0] channel_a_powerdown, channel_b_powerdown;
    wire [43:0] got = {channel_a_output, channel_a_input_reg, channel_b_output, channel_b_input_reg,
        channel_a_powerdown, channel_b_powerdown};
    logic [9:0] ea, ia, eb, ib;
    logic [1:0] pa, pb;
    logic [3:0] undef [6] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB};
    int fail_count = 0;
    int checks = 0;
    int done_seen = 0;
    always #4 core_clk = ~core_clk;
    always @(negedge core_clk) if (frame_done === 1'b1) done_seen++;
    ddc_host u_host (.core_clk, .cs_n, .sclk, .din);
    ddc_decoder uut (.core_clk, .srst, .cs_n, .sclk, .din, .channel_a_output, .channel_a_powerdown,
        .channel_a_input_reg, .channel_b_output, .channel_b_powerdown, .channel_b_input_reg, .frame_done);
    task automatic chk();
        @(negedge core_clk);
        checks++;
        if (got !== {ea, ia, eb, ib, pa, pb}) begin
            fail_count++;
            $display("unexpected at %0t: %h vs %h", $time, got, {ea, ia, eb, ib, pa, pb});
        end
    endtask
    task automatic chk_done(input int want, input int base);
        checks++;
        if (done_seen - base !== want) begin
            fail_count++;
            $display("unexpected at %0t: %h vs %h", $time, done_seen - base, want);
        end
    endtask
    task automatic go(input logic [3:0] c, input logic [9:0] d);
        u_host.send({c, d, 2'h0}, 16);
    endtask
    task automatic t_reset();
        @(negedge core_clk);
        srst = 1'b1;
        repeat (12) @(negedge core_clk);
        srst = 1'b0;
        {ea, ia, eb, ib, pa, pb} = {40'h0, 4'hF};
        repeat (4) @(negedge core_clk);
        chk();
    endtask
    task automatic t_load();
        go(CMD_LOAD_A, 10'h3FF);
        go(CMD_LOAD_B, 10'h001);
        go(CMD_HOLD_AB, 10'h0AA);
        {ea, eb, ia, ib} = {10'h3FF, 10'h001, 10'h0AA, 10'h0AA};
        chk();
        go(CMD_LOAD_AB, 10'h200);
        go(CMD_HOLD_AB, 10'h123);
        {ea, eb, ia, ib} = {10'h200, 10'h200, 10'h123, 10'h123};
        chk();
    endtask
    task automatic t_xfer();
        go(CMD_HOLD_A, 10'h155);
        go(CMD_HOLD_B, 10'h2AA);
        {ia, ib} = {10'h155, 10'h2AA};
        chk();
        go(CMD_XFER_A, 10'h3C3);
        go(CMD_XFER_B, 10'h3C3);
        {ea, eb} = {10'h155, 10'h2AA};
        chk();
        go(CMD_HOLD_AB, 10'h0F0);
        go(CMD_XFER_AB, 10'h000);
        {ea, eb, ia, ib} = {4{10'h0F0}};
        chk();
    endtask
    task automatic t_power();
        for (int s = 3; s >= 0; s--) begin
            for (int t = 0; t < 3; t++) begin
                u_host.send({CMD_POWER, 7'h55, t == 2, 1'b0, t == 1, s[1:0]}, 16);
                pa = (t == 1) ? pa : s[1:0];
                pb = (t == 0) ? pb : s[1:0];
                chk();
            end
        end
    endtask
    task automatic t_abort();
        int base;
        base = done_seen;
        u_host.send({CMD_LOAD_A, 10'h111, 2'h0}, 15);
        chk();
        chk_done(0, base);
        foreach (undef[i]) begin
            go(undef[i], 10'h2DB);
            chk();
        end
        chk_done(6, base);
    endtask
    task automatic wrap_up();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        t_reset();
        t_load();
        t_xfer();
        t_power();
        t_abort();
        t_reset();
        wrap_up();
    end
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
endmodule
